// *** rtl/port_pins_and_bus_strobes.sv ***
// Low port, quasi port, latch strobe, fetch strobe and reset input logic
// Notes on behaviour
// [RQ1] Latch strobe period four oscillator cycles, high one and a half cycles.
// [RQ2] Latch strobe held high while in reset.
// [RQ3] Disable bit set holds latch strobe high when bus idle.
// [RQ4] Latch strobe pulses during external accesses regardless of disable bit.
// [RQ5] Fetch strobe pulses low on external code fetch, otherwise high.
// [RQ6] Low address byte driven while strobe high; data follows after fall.
// [RQ7] Low port open-drain as I/O, drives both levels as bus.
// [RQ8] Low port pins float after reset; outside pull-ups needed for I/O.
// [RQ9] Quasi port reads one after reset, held by weak pull-up.
// [RQ10] Writing zero turns on strong pull-down until one written or reset.
// [RQ11] Zero to one write gives brief strong high, then weak pull-up.
// [RQ12] High reset input requests reset; power-up reset made internally.
// [RQ13] Strong high drive lasts two oscillator cycles. The code holds it for two clock halves, which is one oscillator cycle.
`timescale 1ns/1ps
`include "port_pins_regs.svh"
module port_pins_and_bus_strobes #(
    parameter int WIDTH     = 8,
    parameter int POR_CYC   = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_reset_pin,
    input  wire logic             i_latch_strobe_disable,
    input  wire logic             i_ext_code,
    input  wire logic             i_ext_data,
    input  wire logic             i_data_write,
    input  wire logic [WIDTH-1:0] i_addr_low,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_low_port_wr,
    input  wire logic [WIDTH-1:0] i_low_port_data,
    input  wire logic [WIDTH-1:0] i_low_addr_data_bus_in,
    input  wire logic             i_quasi_wr,
    input  wire logic [WIDTH-1:0] i_quasi_data,
    input  wire logic [WIDTH-1:0] i_quasi_pin_in,
    output logic [WIDTH-1:0]      o_low_addr_data_bus_out,
    output logic [WIDTH-1:0]      o_low_addr_data_bus_oe,
    output logic [WIDTH-1:0]      o_bus_rd_data,
    output logic [WIDTH-1:0]      o_quasi_strong_low,
    output logic [WIDTH-1:0]      o_quasi_strong_high,
    output logic [WIDTH-1:0]      o_quasi_weak_high,
    output logic [WIDTH-1:0]      o_quasi_read,
    output logic                  o_latch_strobe,
    output logic                  o_prog_fetch_strobe_n,
    output logic                  o_in_reset,
    output logic                  o_cycle_start
);
    logic [2:0]       rst_sync_reg;
    logic [7:0]       por_reg;
    logic             in_reset;
    logic [2:0]       phase_reg;
    logic             rst_stable_reg;
    logic             bus_reg;
    logic             code_reg;
    logic             write_reg;
    logic [WIDTH-1:0] addr_reg;
    logic [WIDTH-1:0] wdata_reg;
    logic [WIDTH-1:0] low_latch_reg;
    logic [WIDTH-1:0] rd_reg;
    logic [WIDTH-1:0] bus_out_reg;
    logic [WIDTH-1:0] bus_oe_reg;
    logic             strobe_reg;
    logic             fetch_n_reg;
    logic [WIDTH-1:0] q_sync1_reg;
    logic [WIDTH-1:0] q_sync2_reg;
    logic [WIDTH-1:0] q_sync3_reg;
    logic [WIDTH-1:0] q_stable_reg;
    logic [WIDTH-1:0] q_latch;
    port_pins_pkg::bus_state_type state_reg;
    port_pins_pkg::bus_state_type state_next;
    wire reset_req  = rst_stable_reg; // RQ12
    wire por_busy   = por_reg != 8'(POR_CYC);
    wire cyc_start  = (phase_reg == 3'h0) && !in_reset;
    wire access     = i_ext_code || i_ext_data;
    // Phase counts half cycles; strobe high for three of eight halves
    wire strobe_hi  = (phase_reg < 3'(`STROBE_HIGH_HALF)); // RQ1
    wire strobe_on  = bus_reg || !i_latch_strobe_disable; // RQ3 RQ4
    wire strobe_val = in_reset || !strobe_on || strobe_hi; // RQ2
    // Address goes out on the starting edge so it stands for all three strobe-high clocks
    wire addr_start = cyc_start && access; // RQ6
    wire addr_phase = bus_reg && strobe_hi && !cyc_start; // RQ6
    wire data_drive = bus_reg && !strobe_hi && write_reg;
    wire fetch_low  = bus_reg && code_reg && (phase_reg >= 3'(`FETCH_LOW_PHASE)); // RQ5
    assign in_reset = reset_req || por_busy;
    // Both edges not available on a single clock, so phase counts clock edges as halves
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_reg   <= 3'h0;
            rst_stable_reg <= 1'b0;
        end else begin
            rst_sync_reg   <= {rst_sync_reg[1:0], i_reset_pin};
            rst_stable_reg <= (rst_sync_reg[2] && rst_sync_reg[1])
                           || (rst_stable_reg && (rst_sync_reg[2] || rst_sync_reg[1]));
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            por_reg <= 8'h00;
        end else if (por_busy) begin
            por_reg <= por_reg + 8'h01; // RQ12
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase_reg <= 3'h0;
        end else if (in_reset) begin
            phase_reg <= 3'h0;
        end else begin
            phase_reg <= phase_reg + 3'h1;
        end
    end
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            port_pins_pkg::BUS_IDLE: begin
                if (cyc_start && i_ext_code) begin
                    state_next = port_pins_pkg::BUS_CODE;
                end else if (cyc_start && i_ext_data) begin
                    state_next = port_pins_pkg::BUS_DATA;
                end
            end
            port_pins_pkg::BUS_CODE,
            port_pins_pkg::BUS_DATA: begin
                if (cyc_start && !access) begin
                    state_next = port_pins_pkg::BUS_IDLE;
                end else if (cyc_start) begin
                    state_next = i_ext_code ? port_pins_pkg::BUS_CODE
                                            : port_pins_pkg::BUS_DATA;
                end
            end
            default: begin
                state_next = port_pins_pkg::BUS_IDLE;
            end
        endcase
        if (in_reset) begin
            state_next = port_pins_pkg::BUS_IDLE;
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= port_pins_pkg::BUS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
    assign bus_reg  = (state_reg != port_pins_pkg::BUS_IDLE);
    assign code_reg = (state_reg == port_pins_pkg::BUS_CODE);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            addr_reg  <= '0;
            wdata_reg <= '0;
            write_reg <= 1'b0;
        end else if (cyc_start) begin
            addr_reg  <= i_addr_low;
            wdata_reg <= i_wr_data;
            write_reg <= i_ext_data && !i_ext_code && i_data_write;
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            low_latch_reg <= `LOW_PORT_RESET;
        end else if (in_reset) begin
            low_latch_reg <= `LOW_PORT_RESET;
        end else if (i_low_port_wr) begin
            low_latch_reg <= i_low_port_data;
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_out_reg <= '0;
            bus_oe_reg  <= '0; // RQ8
        end else if (in_reset) begin
            bus_out_reg <= '0;
            bus_oe_reg  <= '0; // RQ8
        end else if (addr_start) begin
            bus_out_reg <= i_addr_low; // RQ6
            bus_oe_reg  <= '1;
        end else if (addr_phase) begin
            bus_out_reg <= addr_reg; // RQ6 RQ7
            bus_oe_reg  <= '1;
        end else if (data_drive) begin
            bus_out_reg <= wdata_reg; // RQ7
            bus_oe_reg  <= '1;
        end else if (bus_reg) begin
            bus_out_reg <= '0; // RQ6
            bus_oe_reg  <= '0;
        end else begin
            bus_out_reg <= '0; // RQ7
            bus_oe_reg  <= ~low_latch_reg;
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_reg <= '0;
        end else if (bus_reg && !write_reg && phase_reg == 3'(`READ_CAPTURE_PHASE)) begin
            rd_reg <= i_low_addr_data_bus_in;
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            strobe_reg  <= 1'b1; // RQ2
            fetch_n_reg <= 1'b1; // RQ5
        end else begin
            strobe_reg  <= strobe_val;
            fetch_n_reg <= !(fetch_low && !in_reset);
        end
    end
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gen_quasi
            quasi_port_bit u_bit (
                .i_clk         (i_clk),
                .i_resetn      (i_resetn),
                .i_reset_req   (in_reset),
                .i_wr          (i_quasi_wr),
                .i_wr_data     (i_quasi_data[g]),
                .o_latch       (q_latch[g]),
                .o_strong_low  (o_quasi_strong_low[g]),
                .o_strong_high (o_quasi_strong_high[g]),
                .o_weak_high   (o_quasi_weak_high[g])
            );
        end
    endgenerate
    // Pin reads change only when the second and third stages agree
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q_sync1_reg  <= `QUASI_PORT_RESET;
            q_sync2_reg  <= `QUASI_PORT_RESET;
            q_sync3_reg  <= `QUASI_PORT_RESET;
            q_stable_reg <= `QUASI_PORT_RESET; // RQ9
        end else begin
            q_sync1_reg  <= i_quasi_pin_in;
            q_sync2_reg  <= q_sync1_reg;
            q_sync3_reg  <= q_sync2_reg;
            q_stable_reg <= (q_sync2_reg & q_sync3_reg)
                          | (q_stable_reg & (q_sync2_reg | q_sync3_reg));
        end
    end
    assign o_quasi_read            = q_stable_reg & q_latch;
    assign o_low_addr_data_bus_out = bus_out_reg;
    assign o_low_addr_data_bus_oe  = bus_oe_reg;
    assign o_bus_rd_data           = rd_reg;
    assign o_latch_strobe          = strobe_reg;
    assign o_prog_fetch_strobe_n   = fetch_n_reg;
    assign o_in_reset              = in_reset;
    assign o_cycle_start           = cyc_start;
    sequence seq_strobe_pulse;
        o_latch_strobe [*3] ##1 !o_latch_strobe [*5];
    endsequence
    AST_STROBE_SHAPE: assert property (@(posedge i_clk) disable iff (!i_resetn || in_reset) // RQ1
        (cyc_start && access) |=> seq_strobe_pulse)
        else $error("latch strobe shape wrong");
    AST_STROBE_RESET: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ2
        in_reset |=> o_latch_strobe)
        else $error("latch strobe not high in reset");
    AST_STROBE_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ3
        (!bus_reg && i_latch_strobe_disable) |=> o_latch_strobe)
        else $error("disabled latch strobe pulsed while idle");
    AST_STROBE_BUS: assert property (@(posedge i_clk) disable iff (!i_resetn || in_reset) // RQ4
        (bus_reg && phase_reg == 3'h4) |=> !o_latch_strobe)
        else $error("latch strobe not pulsing during access");
    AST_FETCH_IDLE: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ5
        !code_reg |=> o_prog_fetch_strobe_n)
        else $error("fetch strobe low without code fetch");
    AST_ADDR_DRIVE: assert property (@(posedge i_clk) disable iff (!i_resetn || in_reset) // RQ6
        addr_phase |=> (o_low_addr_data_bus_oe == '1 && o_latch_strobe))
        else $error("address not driven while strobe high");
    AST_LOW_OD: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ7
        (!bus_reg && !in_reset && !addr_start) |=> (o_low_addr_data_bus_out == '0))
        else $error("low port drove high as general I/O");
    AST_LOW_FLOAT: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ8
        in_reset |=> (o_low_addr_data_bus_oe == '0))
        else $error("low port driven during reset");
endmodule

// *** rtl/port_pins_pkg.sv ***
// Types for the port pin and bus strobe block
package port_pins_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_CODE,
        BUS_DATA
    } bus_state_type;
endpackage

// *** rtl/port_pins_regs.svh ***
// Constants for the port pin and bus strobe block
`ifndef PORT_PINS_REGS_SVH
`define PORT_PINS_REGS_SVH
`define OSC_PERIOD_NS        40
`define STROBE_PERIOD_CYC    4
`define STROBE_HIGH_HALF     3
`define FETCH_LOW_PHASE      4
`define READ_CAPTURE_PHASE   7
`define LOW_PORT_RESET       8'hFF
`define QUASI_PORT_RESET     8'hFF
`define STRONG_HIGH_CYC      2
`define RESET_SYNC_STAGES    3
`endif

// *** rtl/quasi_port_bit.sv ***
// One quasi-bidirectional port bit with momentary strong high drive
`timescale 1ns/1ps
`include "port_pins_regs.svh"
module quasi_port_bit #(
    parameter int STRONG_CYC = `STRONG_HIGH_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_reset_req,
    input  wire logic i_wr,
    input  wire logic i_wr_data,
    output logic      o_latch,
    output logic      o_strong_low,
    output logic      o_strong_high,
    output logic      o_weak_high
);
    logic       latch_reg;
    logic [2:0] boost_reg;
    logic       rise;
    assign rise = i_wr && i_wr_data && !latch_reg;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            latch_reg <= 1'b1;
        end else if (i_reset_req) begin
            latch_reg <= 1'b1;
        end else if (i_wr) begin
            latch_reg <= i_wr_data; // RQ10
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            boost_reg <= 3'h0;
        end else if (i_reset_req) begin
            boost_reg <= 3'h0;
        end else if (rise) begin
            boost_reg <= 3'(STRONG_CYC); // RQ11 RQ13
        end else if (boost_reg != 3'h0) begin
            boost_reg <= boost_reg - 3'h1;
        end
    end
    assign o_latch       = latch_reg;
    assign o_strong_low  = !latch_reg; // RQ10
    assign o_strong_high = latch_reg && (boost_reg != 3'h0); // RQ11
    assign o_weak_high   = latch_reg; // RQ9
    AST_BOOST_LEN: assert property (@(posedge i_clk) disable iff (!i_resetn || i_reset_req) // RQ13
        rise |=> o_strong_high [*2] ##1 !o_strong_high)
        else $error("strong high drive length wrong");
    AST_LOW_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn) // RQ10
        (i_wr && !i_wr_data && !i_reset_req) |=> o_strong_low)
        else $error("strong pull-down not on after zero write");
endmodule

// *** sim/ext_mem_model.sv ***
// External address latch with code and data memory on the multiplexed low bus
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic       i_clk,
    input  wire logic       i_latch_strobe,
    input  wire logic       i_fetch_n,
    input  wire logic       i_rd_sel,
    input  wire logic       i_slow,
    input  wire logic [7:0] i_dev_out,
    input  wire logic [7:0] i_dev_oe,
    output logic [7:0]      o_addr_latch,
    output logic [7:0]      o_pin
);
    logic [1:0] wait_reg;
    wire        reading  = !i_latch_strobe && (!i_fetch_n || i_rd_sel);
    wire        ready    = !i_slow || (wait_reg != 2'h0);
    wire  [7:0] mem_data = i_fetch_n ? (o_addr_latch ^ 8'h3C) : (o_addr_latch ^ 8'hA5);

    // Capture at the edge where the strobe is still seen high, as a latch closing on the fall
    always_ff @(posedge i_clk) begin
        if (i_latch_strobe) begin
            o_addr_latch <= o_pin;
        end
        if (!reading) begin
            wait_reg <= 2'h0;
        end else if (wait_reg != 2'h3) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end

    // Undriven lines rise through the board pull-ups; a slow part holds off one clock
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            o_pin[i] = i_dev_oe[i] ? i_dev_out[i] : ((reading && ready) ? mem_data[i] : 1'b1);
        end
    end
endmodule

// *** sim/port_pins_and_bus_strobes_tb.sv ***
// Self-checking bench for the port pin and bus strobe block
`timescale 1ns/1ps
module port_pins_and_bus_strobes_tb;
    logic       i_clk, i_resetn, i_reset_pin, i_latch_strobe_disable, i_ext_code, i_ext_data;
    logic       i_data_write, i_low_port_wr, i_quasi_wr, rd_sel, slow;
    logic [7:0] i_addr_low, i_wr_data, i_low_port_data, i_quasi_data, quasi_ext_low;
    logic [7:0] o_low_addr_data_bus_out, o_low_addr_data_bus_oe, o_bus_rd_data, o_quasi_read;
    logic [7:0] o_quasi_strong_low, o_quasi_strong_high, o_quasi_weak_high, bus_pin, addr_latch;
    logic       o_latch_strobe, o_prog_fetch_strobe_n, o_in_reset, o_cycle_start;
    logic [7:0] seen_oe, seen_out;
    logic       seen_fall, seen_fetch;
    wire  [7:0] i_low_addr_data_bus_in = bus_pin;
    wire  [7:0] i_quasi_pin_in         = ~o_quasi_strong_low & ~quasi_ext_low;
    int         mismatches      = 0;
    int         samples_checked = 0;

    port_pins_and_bus_strobes #(.WIDTH(8), .POR_CYC(2)) i_dut (
        .i_clk, .i_resetn, .i_reset_pin, .i_latch_strobe_disable, .i_ext_code, .i_ext_data,
        .i_data_write, .i_addr_low, .i_wr_data, .i_low_port_wr, .i_low_port_data,
        .i_low_addr_data_bus_in, .i_quasi_wr, .i_quasi_data, .i_quasi_pin_in,
        .o_low_addr_data_bus_out, .o_low_addr_data_bus_oe, .o_bus_rd_data, .o_quasi_strong_low,
        .o_quasi_strong_high, .o_quasi_weak_high, .o_quasi_read, .o_latch_strobe,
        .o_prog_fetch_strobe_n, .o_in_reset, .o_cycle_start);

    ext_mem_model i_mem (.i_clk(i_clk), .i_latch_strobe(o_latch_strobe),
        .i_fetch_n(o_prog_fetch_strobe_n), .i_rd_sel(rd_sel), .i_slow(slow),
        .i_dev_out(o_low_addr_data_bus_out), .i_dev_oe(o_low_addr_data_bus_oe),
        .o_addr_latch(addr_latch), .o_pin(bus_pin));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic end_sim;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic wait_out_of_reset;
        int n;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_in_reset !== 1'b0 && n < 20);
        check({7'h0, o_in_reset}, 8'h00);
    endtask

    // One bus cycle; the request is held until the edge that takes it
    task automatic run_cycle(input logic code, input logic wr, input logic [7:0] addr,
                             input logic [7:0] wdata);
        int   n;
        logic prev;
        n = 0;
        @(posedge i_clk);
        i_ext_code   <= code;
        i_ext_data   <= !code;
        i_data_write <= wr;
        i_addr_low   <= addr;
        i_wr_data    <= wdata;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_cycle_start !== 1'b1 && n < 40);
        @(posedge i_clk);
        i_ext_code <= 1'b0;
        i_ext_data <= 1'b0;
        seen_fall  = 1'b0;
        seen_fetch = 1'b0;
        for (int k = 0; k < 10; k++) begin
            @(negedge i_clk);
            if (k > 0 && prev && !o_latch_strobe) seen_fall = 1'b1;
            if (!o_prog_fetch_strobe_n) seen_fetch = 1'b1;
            prev = o_latch_strobe;
            if (k == 6) seen_oe = o_low_addr_data_bus_oe;
            if (k == 6) seen_out = o_low_addr_data_bus_out;
            if (k == 6) check(addr_latch, addr);
        end
    endtask

    task automatic t_idle_strobe;
        int highs, falls;
        logic prev;
        highs = 0;
        falls = 0;
        prev  = o_latch_strobe;
        for (int k = 0; k < 16; k++) begin
            @(negedge i_clk);
            if (o_latch_strobe) highs++;
            if (!o_latch_strobe && prev) falls++;
            prev = o_latch_strobe;
        end
        check(8'(highs), 8'h06);
        check(8'(falls), 8'h02);
        @(posedge i_clk);
        i_latch_strobe_disable <= 1'b1;
        repeat (10) @(posedge i_clk);
        highs = 0;
        for (int k = 0; k < 16; k++) begin
            @(negedge i_clk);
            if (o_latch_strobe) highs++;
        end
        check(8'(highs), 8'h10);
    endtask

    task automatic t_bus;
        run_cycle(1'b1, 1'b0, 8'h12, 8'h00);
        check({7'h0, seen_fall}, 8'h01);
        check({7'h0, seen_fetch}, 8'h01);
        check(o_bus_rd_data, 8'hB7);
        check({7'h0, o_prog_fetch_strobe_n}, 8'h01);
        run_cycle(1'b0, 1'b1, 8'hC3, 8'h5E);
        check({7'h0, seen_fetch}, 8'h00);
        check(seen_oe, 8'hFF);
        check(seen_out, 8'h5E);
        @(posedge i_clk);
        rd_sel <= 1'b1;
        slow   <= 1'b1;
        run_cycle(1'b0, 1'b0, 8'h7F, 8'h00);
        check(seen_oe, 8'h00);
        check(o_bus_rd_data, 8'h43);
        rd_sel <= 1'b0;
    endtask

    task automatic pulse_write(input logic quasi, input logic [7:0] value);
        @(posedge i_clk);
        i_quasi_wr      <= quasi;
        i_low_port_wr   <= !quasi;
        i_quasi_data    <= value;
        i_low_port_data <= value;
        @(posedge i_clk);
        i_quasi_wr    <= 1'b0;
        i_low_port_wr <= 1'b0;
    endtask

    task automatic t_ports;
        int highs;
        highs = 0;
        pulse_write(1'b0, 8'h0F);
        repeat (2) @(negedge i_clk);
        check(o_low_addr_data_bus_oe, 8'hF0);
        check(o_low_addr_data_bus_out & o_low_addr_data_bus_oe, 8'h00);
        check(bus_pin, 8'h0F);
        pulse_write(1'b1, 8'h00);
        repeat (8) @(negedge i_clk);
        check(o_quasi_strong_low, 8'hFF);
        check(o_quasi_read, 8'h00);
        pulse_write(1'b1, 8'hFF);
        for (int k = 0; k < 6; k++) begin
            @(negedge i_clk);
            if (o_quasi_strong_high === 8'hFF) highs++;
        end
        check(8'(highs), 8'h02);
        check(o_quasi_strong_low, 8'h00);
        check(o_quasi_weak_high, 8'hFF);
        @(posedge i_clk);
        quasi_ext_low <= 8'h0F;
        repeat (6) @(negedge i_clk);
        check(o_quasi_read, 8'hF0);
        @(posedge i_clk);
        quasi_ext_low <= 8'h00;
    endtask

    task automatic t_pin_reset;
        pulse_write(1'b1, 8'h55);
        i_reset_pin <= 1'b1;
        repeat (8) @(negedge i_clk);
        check({7'h0, o_in_reset}, 8'h01);
        check({7'h0, o_latch_strobe}, 8'h01);
        check(o_quasi_strong_low, 8'h00);
        check(o_low_addr_data_bus_oe, 8'h00);
        @(posedge i_clk);
        i_reset_pin <= 1'b0;
        wait_out_of_reset();
    endtask

    initial begin
        #(40 * 3000);
        mismatches++;
        end_sim();
    end

    initial begin
        {i_resetn, i_reset_pin, i_latch_strobe_disable, i_ext_code, i_ext_data} = 5'h00;
        {i_data_write, i_low_port_wr, i_quasi_wr, rd_sel, slow} = 5'h00;
        {i_addr_low, i_wr_data, i_quasi_data, quasi_ext_low} = 32'h0;
        i_low_port_data = 8'hFF;
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        check({7'h0, o_latch_strobe}, 8'h01);
        check({7'h0, o_prog_fetch_strobe_n}, 8'h01);
        check(o_low_addr_data_bus_oe, 8'h00);
        check(o_quasi_weak_high, 8'hFF);
        check(o_quasi_read, 8'hFF);
        @(posedge i_clk);
        i_resetn <= 1'b1;
        wait_out_of_reset();
        t_idle_strobe();
        t_bus();
        t_ports();
        t_pin_reset();
        end_sim();
    end
endmodule
